// [design/reservation_defs.svh]
// Reservation access constants: offsets, fields, resets, timing.
// Assumes a 50 MHz clk and byte-addressed 32-bit AXI4-Lite registers.
// Operation
// - Equal owner, target, type, stream: one reservation
// - Parse elements; transmit only as type permits
// - Transaction must end gap before block end
// - Alien beacon period: silent except own beacon
// - Hard: owner and targets only, owner starts
// - Release frees block after its duration
// - Hard data: tag and destination must match
// - Soft owner starts block without backoff
// - Soft owner chains within short gap
// - Soft no-backoff data needs match
// - Hidden neighbours of soft target stay silent
// - Private: non-participants stay silent
// - Contention type: ordinary contention access
// - Three cases mark slot unavailable
// - No negotiation over slots held unless denied
// - Advertise capability; negotiate only as owner
// - Alien period: granted element unasked
// - Contention grant needs prior element
// - Owner fills target, accepted, stream
// - Unicast needs both sides granted
`ifndef RESERVATION_DEFS_SVH
`define RESERVATION_DEFS_SVH

`define CLK_NS 20
`define SLOTS 16
`define STREAMS 8
`define SIFS_NS 10000
`define GUARD_NS 12000
`define SLOT_NS 64000
`define SIFS_CYC ((`SIFS_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC ((`SIFS_NS + `GUARD_NS + `CLK_NS - 1) / `CLK_NS)
`define SLOT_CYC (`SLOT_NS / `CLK_NS)

`define OFS_CTRL 8'h00
`define OFS_SEL 8'h04
`define OFS_SLOT 8'h08
`define OFS_BP 8'h0C
`define OFS_AVAIL 8'h10
`define OFS_NEG 8'h14
`define OFS_RESULT 8'h18
`define OFS_STATUS 8'h1C

`define CTRL_CAP_BIT 12
`define CTRL_EN_BIT 13
`define NEG_NEW_BIT 8
`define NEG_EXPL_BIT 12
`define NEG_PEER_BIT 13

`define RST_DEV_ADDR 8'h00
`define RST_LIMIT 4'h3
`define RST_CAP 1'b0
`define RST_EN 1'b1

`endif

// [design/reservation_pkg.sv]
// Types shared by the block and its bench.
// Assumes the constants header is compiled alongside.
package reservation_pkg;

   // Internal encodings
   typedef enum logic [2:0] {
      RT_ALIEN = 3'h0,
      RT_HARD = 3'h1,
      RT_SOFT = 3'h3,
      RT_PRIVATE = 3'h2,
      RT_CONTENTION = 3'h6
   } rtype_t;

   typedef enum logic [1:0] {
      RC_ACCEPTED = 2'h0,
      RC_CONFLICT = 2'h1,
      RC_PENDING = 2'h2,
      RC_DENIED = 2'h3
   } reason_t;

   typedef enum logic [2:0] {
      FK_DATA = 3'h0,
      FK_AGG = 3'h1,
      FK_COMMAND = 3'h2,
      FK_CONTROL = 3'h3,
      FK_BEACON = 3'h4
   } frame_kind_t;

   typedef struct packed {
      logic [7:0] owner_addr;
      logic [7:0] target_addr;
      logic [3:0] spare;
      logic [2:0] stream;
      logic valid;
      logic hidden;
      logic peer_granted;
      logic granted;
      reason_t reason;
      rtype_t rtype;
   } slot_entry_t;

   typedef struct packed {
      logic valid;
      frame_kind_t kind;
      logic [7:0] dest;
      logic [2:0] tag;
      logic mcast_member;
      logic unicast;
      logic response;
      logic [15:0] len;
   } tx_req_t;

   typedef struct packed {
      logic valid;
      logic grant;
      logic no_backoff;
   } tx_ans_t;

endpackage : reservation_pkg

// [design/reservation_access.sv]
`timescale 1ns/1ps
// Reservation access: slot table, transmit permission, availability, negotiation.
// Assumes slot, superframe and transmit signals come from MAC logic on clk.
`include "reservation_defs.svh"
module reservation_access
   import reservation_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic slot_start,
   input wire logic [3:0] slot_index,
   input wire logic superframe_start,
   input wire logic alien_detect,
   input wire logic [3:0] alien_slot,
   input wire logic release_rx,
   input wire logic [15:0] release_cycles,
   input wire tx_req_t tx_req,
   input wire logic tx_done,
   output tx_ans_t tx_ans,
   output logic cap_explicit,
   output logic [15:0] avail_map
);
   localparam int N = `SLOTS;
   localparam int S = `STREAMS;

   logic [7:0] dev_addr_reg;
   logic [3:0] limit_reg;
   logic enable_reg;
   logic [3:0] sel_reg;
   slot_entry_t slot_reg [N];
   logic [4:0] bp_age_reg [N];
   logic [N-1:0] prev_pca_reg;
   logic [4:0] s_age_reg [S];
   logic [7:0] s_tgt_reg [S];
   logic [31:0] result_reg;
   logic [3:0] cur_slot_reg;
   logic [15:0] slot_cnt_reg;
   logic block_first_reg;
   logic released_reg;
   logic release_pend_reg;
   logic [15:0] release_cnt_reg;
   logic chain_reg;
   logic [15:0] chain_cnt_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
      input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      return r;
   endfunction : merge

   function automatic logic same_key(input slot_entry_t a, input slot_entry_t b);
      return a.valid && b.valid && a.owner_addr == b.owner_addr &&
         a.target_addr == b.target_addr && a.rtype == b.rtype && a.stream == b.stream;
   endfunction : same_key

   // Write channel
   logic wr_go;
   logic [7:0] wa;
   logic wr_ctrl, wr_sel, wr_slot, wr_bp, wr_neg, wr_hit;
   logic [31:0] nd;
   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wa = {waddr_reg[7:2], 2'b00};
   assign nd = merge(32'h0000_0000, wdata_reg, wstrb_reg);

   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_sel = 1'b0;
      wr_slot = 1'b0;
      wr_bp = 1'b0;
      wr_neg = 1'b0;
      wr_hit = 1'b1;
      if (wa == `OFS_CTRL)
         wr_ctrl = wr_go;
      else if (wa == `OFS_SEL)
         wr_sel = wr_go;
      else if (wa == `OFS_SLOT)
         wr_slot = wr_go;
      else if (wa == `OFS_BP)
         wr_bp = wr_go;
      else if (wa == `OFS_NEG)
         wr_neg = wr_go;
      else
         wr_hit = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Control registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dev_addr_reg <= `RST_DEV_ADDR;
         limit_reg <= `RST_LIMIT;
         cap_explicit <= `RST_CAP;
         enable_reg <= `RST_EN;
         sel_reg <= 4'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            dev_addr_reg <= nd[7:0];
            limit_reg <= nd[11:8];
            cap_explicit <= nd[`CTRL_CAP_BIT];
            enable_reg <= nd[`CTRL_EN_BIT];
         end
         if (wr_sel)
            sel_reg <= nd[3:0];
      end
   end

   // Slot table; alien detection wins
   slot_entry_t wr_entry;
   always_comb
   begin
      wr_entry = slot_entry_t'(merge(slot_reg[sel_reg], wdata_reg, wstrb_reg));
      if (wr_entry.rtype == RT_CONTENTION && !prev_pca_reg[sel_reg])
         wr_entry.granted = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_reg <= '{default: '0};
      end
      else
      begin
         if (wr_slot)
            slot_reg[sel_reg] <= wr_entry;
         if (alien_detect)
            slot_reg[alien_slot] <= '{dev_addr_reg, dev_addr_reg, 4'h0, 3'h0, 1'b1, 1'b0,
               1'b1, 1'b1, RC_ACCEPTED, RT_ALIEN};
      end
   end

   // Per-slot ageing, availability, blocking
   logic [N-1:0] blocked;
      for (genvar gi = 0; gi < N; gi++)
      begin : g_slot
         logic own_el;
         assign own_el = slot_reg[gi].valid && (slot_reg[gi].owner_addr == dev_addr_reg ||
            slot_reg[gi].target_addr == dev_addr_reg);
         assign blocked[gi] = slot_reg[gi].valid && slot_reg[gi].reason != RC_DENIED;
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               bp_age_reg[gi] <= 5'h00;
               prev_pca_reg[gi] <= 1'b0;
               avail_map[gi] <= 1'b1;
            end
            else
            begin
               if (wr_bp && nd[gi])
                  bp_age_reg[gi] <= {1'b0, limit_reg} + 5'h01;
               else if (superframe_start && bp_age_reg[gi] != 5'h00)
                  bp_age_reg[gi] <= bp_age_reg[gi] - 5'h01;
               if (superframe_start)
                  prev_pca_reg[gi] <= own_el && slot_reg[gi].rtype == RT_CONTENTION;
               avail_map[gi] <= !((own_el && slot_reg[gi].granted) ||
                  (slot_reg[gi].valid && !own_el) || bp_age_reg[gi] != 5'h00);
            end
         end
      end

   // Stream numbers in use per target
   logic [S-1:0] used_now;
   logic [S-1:0] tgt_busy;
   logic [2:0] free_s;
   logic free_ok;
   always_comb
   begin
      used_now = '0;
      tgt_busy = '0;
      free_s = 3'h0;
      free_ok = 1'b0;
      for (int s = 0; s < S; s++)
      begin
         for (int i = 0; i < N; i++)
         begin
            if (slot_reg[i].valid && slot_reg[i].owner_addr == dev_addr_reg &&
               slot_reg[i].stream == 3'(s))
            begin
               used_now[s] = used_now[s] | (slot_reg[i].target_addr == s_tgt_reg[s]);
               tgt_busy[s] = tgt_busy[s] | (slot_reg[i].target_addr == nd[7:0]);
            end
         end
         if (s_age_reg[s] != 5'h00 && s_tgt_reg[s] == nd[7:0])
            tgt_busy[s] = 1'b1;
      end
      for (int s = S - 1; s >= 0; s--)
      begin
         if (!tgt_busy[s])
         begin
            free_s = 3'(s);
            free_ok = 1'b1;
         end
      end
   end

   // Owner negotiation result
   logic neg_refused;
   logic [2:0] neg_stream;
   assign neg_stream = nd[`NEG_NEW_BIT] ? free_s : nd[11:9];
   assign neg_refused = (|(nd[31:16] & blocked)) ||
      (nd[`NEG_EXPL_BIT] && !(nd[`NEG_PEER_BIT] && cap_explicit)) ||
      (nd[`NEG_NEW_BIT] && !free_ok);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_reg <= 32'h0000_0000;
         s_age_reg <= '{default: 5'h00};
         s_tgt_reg <= '{default: 8'h00};
      end
      else
      begin
         if (superframe_start)
         begin
            for (int s = 0; s < S; s++)
            begin
               if (used_now[s])
                  s_age_reg[s] <= {1'b0, limit_reg} + 5'h01;
               else if (s_age_reg[s] != 5'h00)
                  s_age_reg[s] <= s_age_reg[s] - 5'h01;
            end
         end
         if (wr_neg)
         begin
            result_reg <= {nd[31:16], 1'b1, neg_refused, neg_stream, RC_ACCEPTED, 1'b0,
               nd[7:0]};
            if (!neg_refused && nd[`NEG_NEW_BIT])
            begin
               s_age_reg[free_s] <= {1'b0, limit_reg} + 5'h01;
               s_tgt_reg[free_s] <= nd[7:0];
            end
         end
      end
   end

   // Slot timing, release, chaining
   slot_entry_t cur;
   logic [4:0] run;
   logic [19:0] remaining;
   always_comb
   begin
      cur = slot_reg[cur_slot_reg];
      run = 5'h00;
      for (int k = N - 1; k >= 1; k--)
      begin
         if (int'(cur_slot_reg) + k < N)
         begin
            if (same_key(slot_reg[4'(int'(cur_slot_reg) + k)], cur))
               run = run + 5'h01;
            else
               run = 5'h00;
         end
      end
      remaining = {4'h0, slot_cnt_reg} + 20'(run) * 20'(`SLOT_CYC);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_slot_reg <= 4'h0;
         slot_cnt_reg <= 16'h0000;
         block_first_reg <= 1'b0;
         released_reg <= 1'b0;
         release_pend_reg <= 1'b0;
         release_cnt_reg <= 16'h0000;
      end
      else if (slot_start)
      begin
         cur_slot_reg <= slot_index;
         slot_cnt_reg <= 16'(`SLOT_CYC - 1);
         block_first_reg <= !same_key(slot_reg[slot_index], cur);
         if (!same_key(slot_reg[slot_index], cur))
         begin
            released_reg <= 1'b0;
            release_pend_reg <= 1'b0;
         end
      end
      else
      begin
         if (slot_cnt_reg != 16'h0000)
            slot_cnt_reg <= slot_cnt_reg - 16'h0001;
         if (release_rx && (cur.rtype == RT_HARD || cur.rtype == RT_PRIVATE))
         begin
            release_pend_reg <= 1'b1;
            release_cnt_reg <= release_cycles;
         end
         else if (release_pend_reg && release_cnt_reg == 16'h0000)
         begin
            release_pend_reg <= 1'b0;
            released_reg <= 1'b1;
         end
         else if (release_pend_reg)
            release_cnt_reg <= release_cnt_reg - 16'h0001;
      end
   end

   logic own_o, own_t;
   assign own_o = cur.valid && cur.owner_addr == dev_addr_reg;
   assign own_t = cur.valid && cur.target_addr == dev_addr_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chain_reg <= 1'b0;
         chain_cnt_reg <= 16'h0000;
      end
      else if (slot_start)
         chain_reg <= 1'b0;
      else if (tx_done && own_o && cur.rtype == RT_SOFT)
      begin
         chain_reg <= 1'b1;
         chain_cnt_reg <= 16'(`SIFS_CYC);
      end
      else if (chain_reg && chain_cnt_reg == 16'h0000)
         chain_reg <= 1'b0;
      else if (chain_reg)
         chain_cnt_reg <= chain_cnt_reg - 16'h0001;
   end

   // Transmit permission
   rtype_t eff;
   logic fits, data_ok, uni_ok, start_win, grant, nb;
   always_comb
   begin
      eff = (!cur.valid || released_reg) ? RT_CONTENTION : cur.rtype;
      fits = !cur.valid || ({4'h0, tx_req.len} + 20'(`GAP_CYC) <= remaining);
      data_ok = !(tx_req.kind == FK_DATA || tx_req.kind == FK_AGG) ||
         (tx_req.tag == cur.stream && (tx_req.dest == cur.target_addr ||
         tx_req.mcast_member));
      uni_ok = !(tx_req.unicast && own_o) || (cur.granted && cur.peer_granted);
      start_win = block_first_reg && slot_cnt_reg >= 16'(`SLOT_CYC - `SIFS_CYC);
      grant = 1'b0;
      nb = 1'b0;
      case (eff)
         RT_ALIEN:
            grant = tx_req.kind == FK_BEACON;
         RT_HARD:
         begin
            grant = (own_o || (own_t && tx_req.response)) && data_ok && uni_ok && fits;
            nb = grant;
         end
         RT_SOFT:
         begin
            if (!cur.hidden)
            begin
               grant = fits;
               nb = own_o && (start_win || chain_reg) && data_ok && uni_ok && fits;
            end
         end
         RT_PRIVATE:
         begin
            grant = (own_o || own_t) && uni_ok && fits;
            nb = grant;
         end
         default:
            grant = fits;
      endcase
   end

   logic last_grant_reg, last_nb_reg;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_ans <= '0;
         last_grant_reg <= 1'b0;
         last_nb_reg <= 1'b0;
      end
      else
      begin
         tx_ans.valid <= tx_req.valid;
         tx_ans.grant <= tx_req.valid && enable_reg && grant;
         tx_ans.no_backoff <= tx_req.valid && enable_reg && grant && nb;
         if (tx_req.valid)
         begin
            last_grant_reg <= enable_reg && grant;
            last_nb_reg <= enable_reg && grant && nb;
         end
      end
   end

   // Read channel
   logic [31:0] rd_data;
   logic rd_hit;
   logic [7:0] ra;
   assign ra = {s_axi_araddr[7:2], 2'b00};
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      if (ra == `OFS_CTRL)
         rd_data = {18'h0_0000, enable_reg, cap_explicit, limit_reg, dev_addr_reg};
      else if (ra == `OFS_SEL)
         rd_data = {28'h000_0000, sel_reg};
      else if (ra == `OFS_SLOT)
         rd_data = slot_reg[sel_reg];
      else if (ra == `OFS_BP || ra == `OFS_NEG)
         rd_data = 32'h0000_0000;
      else if (ra == `OFS_AVAIL)
         rd_data = {16'h0000, avail_map};
      else if (ra == `OFS_RESULT)
         rd_data = result_reg;
      else if (ra == `OFS_STATUS)
         rd_data = {24'h00_0000, last_nb_reg, last_grant_reg, chain_reg, released_reg,
            cur_slot_reg};
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : reservation_access

// [tb/reservation_access_chk.sv]
// Port timing checker for reservation_access.
// Assumes a bind into reservation_access; sees its ports only.
`timescale 1ns/1ps
module reservation_access_chk
   import reservation_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tx_req_t tx_req,
   input wire tx_ans_t tx_ans
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_ans;
      tx_req.valid |=> tx_ans.valid;
   endproperty
   a_ans: assert property (p_ans) else $error("answer missing");
   property p_quiet;
      !tx_req.valid |=> !tx_ans.valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer unasked");
   property p_nb;
      tx_ans.valid && tx_ans.no_backoff |-> tx_ans.grant;
   endproperty
   a_nb: assert property (p_nb) else $error("no_backoff without grant");
   property p_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write response late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd: assert property (p_rd) else $error("read data late");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready during response");
endmodule : reservation_access_chk

bind reservation_access reservation_access_chk chk (.*);

// [tb/slot_source.sv]
// Model of the MAC slot and superframe timing.
// Assumes the bench requests slots and superframes on clk.
`timescale 1ns/1ps
module slot_source
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [3:0] idx,
   input wire logic sf,
   output logic slot_start,
   output logic [3:0] slot_index,
   output logic superframe_start
);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_start <= 1'b0;
         slot_index <= 4'h0;
         superframe_start <= 1'b0;
      end
      else
      begin
         slot_start <= go;
         slot_index <= go ? idx : ~slot_index;
         superframe_start <= sf;
      end
   end
endmodule : slot_source

// [tb/channel_reservation_access_tb.sv]
// Self-checking bench for the reservation access block.
// Assumes slot_source for slot timing.
`timescale 1ns/1ps
`include "reservation_defs.svh"
module channel_reservation_access_tb
   import reservation_pkg::*;
   ;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, sf = 1'b0;
   logic [3:0] idx = 4'h0, s_axi_wstrb = 4'hF, alien_slot = 4'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, alien_detect = 1'b0;
   logic release_rx = 1'b0, tx_done = 1'b0;
   logic [15:0] release_cycles = 16'h0, avail_map;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic slot_start, superframe_start, cap_explicit, g;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [3:0] slot_index;
   logic [2:0] tg;
   logic [7:0] ds;
   tx_req_t tx_req = '0;
   tx_ans_t tx_ans;
   slot_entry_t e;
   frame_kind_t k;
   int bad_count = 0, checks = 0;
   reservation_access dut (.*);
   slot_source src (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 200);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      int n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 200);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic tx(input frame_kind_t fk, input logic [2:0] t, input logic [7:0] d,
         input logic u, input logic eg, input logic en, input logic [15:0] ln = 16'h0010);
      @(posedge clk);
      tx_req <= '{1'b1, fk, d, t, 1'b0, u, 1'b0, ln};
      @(posedge clk);
      tx_req.valid <= 1'b0;
      #1 check({29'h0, tx_ans}, {29'h0, 1'b1, eg, en});
   endtask : tx
   task automatic new_slot(input logic [3:0] i);
      @(posedge clk);
      go <= 1'b1;
      idx <= i;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : new_slot
   task automatic set_slot(input logic [3:0] i, input slot_entry_t v);
      axi_write(`OFS_SEL, {28'h0, i});
      axi_write(`OFS_SLOT, v);
   endtask : set_slot
   task automatic neg(input logic [31:0] w);
      axi_write(`OFS_NEG, w);
      repeat (2) @(posedge clk);
      axi_read(`OFS_RESULT);
   endtask : neg
   function automatic slot_entry_t mk(rtype_t t, logic [2:0] s, logic [7:0] tt, logic [7:0] o);
      mk = '{o, tt, 4'h0, s, 1'b1, 1'b0, 1'b1, 1'b1, RC_ACCEPTED, t};
   endfunction : mk
   function automatic logic exp_hard(frame_kind_t fk, logic [2:0] t, logic [7:0] d);
      exp_hard = fk == FK_COMMAND || fk == FK_CONTROL || (t == 3'h5 && d == 8'h66);
   endfunction : exp_hard
   initial
      forever #10 clk = ~clk;
   initial
   begin
      #400000;
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(23315));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      axi_read(`OFS_CTRL);
      check(rd, 32'h0000_2300);
      check({16'h0, avail_map}, 32'h0000_FFFF);
      axi_read(8'h20);
      check({rd[29:0], rsp}, 32'h2);
      axi_write(8'h24, 32'h1);
      check({30'h0, rsp}, 32'h2);
      axi_write(`OFS_CTRL, 32'h0000_335A);
      repeat (2) @(posedge clk);
      check({31'h0, cap_explicit}, 32'h1);
      axi_write(`OFS_BP, 32'h0000_00F0);
      repeat (2) @(posedge clk);
      check({16'h0, avail_map}, 32'h0000_FF0F);
      axi_read(`OFS_AVAIL);
      check(rd, 32'h0000_FF0F);
      repeat (6)
      begin
         @(posedge clk);
         sf <= 1'b1;
         @(posedge clk);
         sf <= 1'b0;
      end
      repeat (2) @(posedge clk);
      check({16'h0, avail_map}, 32'h0000_FFFF);
      $display("test registers done");
      new_slot(4'h0);
      tx(FK_DATA, 3'h0, 8'h12, 1'b1, 1'b1, 1'b0);
      set_slot(4'hF, mk(RT_HARD, 3'h5, 8'h66, 8'h5A));
      set_slot(4'hE, mk(RT_HARD, 3'h2, 8'h22, 8'h11));
      axi_read(`OFS_SLOT);
      check(rd, mk(RT_HARD, 3'h2, 8'h22, 8'h11));
      check({16'h0, avail_map}, 32'h0000_3FFF);
      new_slot(4'hF);
      tx(FK_DATA, 3'h5, 8'h66, 1'b1, 1'b1, 1'b1);
      tx(FK_DATA, 3'h4, 8'h66, 1'b1, 1'b0, 1'b0);
      tx(FK_AGG, 3'h5, 8'h67, 1'b1, 1'b0, 1'b0);
      tx(FK_CONTROL, 3'h4, 8'h67, 1'b1, 1'b1, 1'b1);
      tx(FK_COMMAND, 3'h0, 8'h66, 1'b1, 1'b0, 1'b0, 16'hFFFF);
      for (int i = 0; i < 24; i++)
      begin
         k = frame_kind_t'($urandom_range(3));
         tg = $urandom_range(1) ? 3'h5 : 3'($urandom);
         ds = $urandom_range(1) ? 8'h66 : 8'($urandom);
         g = exp_hard(k, tg, ds);
         tx(k, tg, ds, 1'b1, g, g);
      end
      new_slot(4'hE);
      tx(FK_COMMAND, 3'h0, 8'h11, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      release_cycles <= 16'd20;
      release_rx <= 1'b1;
      @(posedge clk);
      release_rx <= 1'b0;
      tx(FK_COMMAND, 3'h0, 8'h11, 1'b0, 1'b0, 1'b0);
      repeat (30) @(posedge clk);
      tx(FK_DATA, 3'h0, 8'h11, 1'b1, 1'b1, 1'b0);
      e = mk(RT_HARD, 3'h1, 8'h77, 8'h5A);
      e.peer_granted = 1'b0;
      set_slot(4'hD, e);
      new_slot(4'hD);
      tx(FK_DATA, 3'h1, 8'h77, 1'b1, 1'b0, 1'b0);
      tx(FK_DATA, 3'h1, 8'h77, 1'b0, 1'b1, 1'b1);
      $display("test hard done");
      @(posedge clk);
      alien_slot <= 4'h2;
      alien_detect <= 1'b1;
      @(posedge clk);
      alien_detect <= 1'b0;
      new_slot(4'h2);
      tx(FK_DATA, 3'h0, 8'h12, 1'b0, 1'b0, 1'b0);
      axi_write(`OFS_SEL, 32'h2);
      axi_read(`OFS_SLOT);
      check(rd & 32'h0000_0127, 32'h0000_0120);
      set_slot(4'h9, mk(RT_SOFT, 3'h1, 8'h44, 8'h5A));
      new_slot(4'h9);
      tx(FK_COMMAND, 3'h0, 8'h44, 1'b1, 1'b1, 1'b1);
      tx(FK_DATA, 3'h2, 8'h44, 1'b1, 1'b1, 1'b0);
      repeat (600) @(posedge clk);
      tx(FK_COMMAND, 3'h0, 8'h44, 1'b1, 1'b1, 1'b0);
      @(posedge clk);
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      tx(FK_COMMAND, 3'h0, 8'h44, 1'b1, 1'b1, 1'b1);
      $display("test soft done");
      neg(32'h8000_0133);
      check({31'h0, rd[14]}, 32'h1);
      neg(32'h0008_1133);
      check({31'h0, rd[14]}, 32'h1);
      neg(32'h0008_0133);
      check(rd, 32'h0008_8033);
      $display("test negotiation done");
      report_and_stop();
   end
endmodule : channel_reservation_access_tb
